// ==== pkg/mirror_defines.svh ====
`ifndef MIRROR_DEFINES_SVH
`define MIRROR_DEFINES_SVH

// chassis slots and readback grouping
`define MR_SLOT_MIN       3'h1
`define MR_SLOT_MAX       3'h5
`define MR_PAGE_SIZE      16'h000A
`define MR_VIEW_BYTES     8'h28

// descriptor widths
`define MR_MOD_W          3
`define MR_PORT_W         4
`define MR_TAG_W          8
`define MR_FWD_W          16
`define MR_ADDR_W         8

// register offsets
`define MR_REG_MODE       8'h00
`define MR_REG_CMD        8'h04
`define MR_REG_SAVE       8'h08
`define MR_REG_STATUS     8'h0C
`define MR_REG_PAGE       8'h10
`define MR_REG_DROPS      8'h14
`define MR_REG_VIEW       8'h40

// command and view word fields
`define MR_F_SMOD_LSB     0
`define MR_F_SPORT_LSB    4
`define MR_F_DMOD_LSB     8
`define MR_F_DPORT_LSB    12
`define MR_F_ERR_OFF_BIT  16
`define MR_F_OP_ADD_BIT   24
`define MR_F_VALID_BIT    31

// status word fields
`define MR_ST_SAVED_BIT   0
`define MR_ST_CMDERR_BIT  1
`define MR_ST_NEXT_BIT    2
`define MR_ST_PREV_BIT    3

// reset values and the drop counter ceiling
`define MR_MODE_RST       5'h00
`define MR_PAGE_RST       8'h00
`define MR_WORD_RST       32'h0000_0000
`define MR_DROP_MAX       16'hFFFF

`endif

// ==== pkg/mirror_pkg.sv ====
package mirror_pkg;
`include "mirror_defines.svh"

    typedef struct packed {
        logic                   err_off;
        logic [`MR_PORT_W-1:0]  dst_port;
        logic [`MR_MOD_W-1:0]   dst_mod;
        logic [`MR_PORT_W-1:0]  src_port;
        logic [`MR_MOD_W-1:0]   src_mod;
    } entry_s;

    typedef struct packed {
        logic [`MR_TAG_W-1:0]   tag;
        logic                   err;
        logic [`MR_FWD_W-1:0]   fwd;
        logic [`MR_PORT_W-1:0]  src_port;
        logic [`MR_MOD_W-1:0]   src_mod;
    } frame_s;

    typedef struct packed {
        logic [`MR_TAG_W-1:0]   tag;
        logic                   err;
        logic [`MR_PORT_W-1:0]  dst_port;
        logic [`MR_MOD_W-1:0]   dst_mod;
    } copy_s;

endpackage

// ==== verilog/entry_hit.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "mirror_defines.svh"
module entry_hit
    import mirror_pkg::*;
(
    // entry and key
    input  wire entry_s                 ent,
    input  wire logic [`MR_MOD_W-1:0]   src_mod,
    input  wire logic [`MR_PORT_W-1:0]  src_port,
    input  wire logic [`MR_MOD_W-1:0]   dst_mod,
    input  wire logic [`MR_PORT_W-1:0]  dst_port,
    input  wire logic                   use_dst,
    // result
    output logic                        hit
);
    assign hit = (ent.src_mod == src_mod) && (ent.src_port == src_port) &&
                 (!use_dst || ((ent.dst_mod == dst_mod) && (ent.dst_port == dst_port)));
endmodule
`default_nettype wire

// ==== verilog/lowest_one.sv ====
`timescale 1ns/10ps
`default_nettype none
module lowest_one #(
    parameter int W  = 8,
    parameter int IW = 3
) (
    // request vector
    input  wire logic [W-1:0]   vec,
    // lowest set bit
    output logic                found,
    output logic [IW-1:0]       idx
);
    always_comb begin
        found = 1'b0;
        idx   = '0;
        for (int i = W - 1; i >= 0; i--) begin
            if (vec[i]) begin
                found = 1'b1;
                idx   = IW'(i);
            end
        end
    end
endmodule
`default_nettype wire

// ==== verilog/port_mirror_redirect.sv ====
// How it works
// - copies are made only while the source slot runs transparent bridging.
// - module identifiers outside slots one to five are refused.
// - a module identifier is the slot number holding the module.
// - one source may list many destinations; each gets a copy.
// - a port may be source of some entries and destination of others.
// - every arriving frame is forwarded normally regardless of mirroring.
// - error-copy on sends errored and valid frames; off sends only valid.
// - a new entry takes error copying from the command's err_off bit; a plain add turns it on.
// - management adds or deletes a source and destination pair.
// - readback shows groups of ten; next and previous only where groups exist.
// - staged changes take effect together on save, which is confirmed.
`timescale 1ns/10ps
`default_nettype none
`include "mirror_defines.svh"
module port_mirror_redirect
    import mirror_pkg::*;
#(
    parameter int NENT = 32
) (
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   rstn,
    // register port
    input  wire logic [`MR_ADDR_W-1:0]  addr,
    input  wire logic [31:0]            wr_data,
    input  wire logic                   wr_en,
    input  wire logic                   rd_en,
    output logic [31:0]                 rd_data,
    // frames from switch ports
    input  wire logic                   frm_valid,
    input  wire frame_s                 frm,
    // normal forwarding
    output logic                        fwd_valid,
    output frame_s                      fwd_frame,
    // mirrored copies toward monitor ports
    input  wire logic                   mir_ready,
    output logic                        mir_valid,
    output copy_s                       mir_copy
);
    localparam int CW = $clog2(NENT + 1);
    localparam int IW = $clog2(NENT);

    entry_s              stg_mem [NENT];
    entry_s              act_mem [NENT];
    logic [CW-1:0]       stg_cnt_reg;
    logic [CW-1:0]       act_cnt_reg;
    logic [4:0]          mode_reg;
    logic [7:0]          page_reg;
    logic                saved_reg;
    logic                cmd_err_reg;
    logic [15:0]         drop_reg;
    logic [NENT-1:0]     pend_reg;
    frame_s              cur_reg;
    logic [31:0]         rd_next;

    function automatic logic slot_ok(input logic [`MR_MOD_W-1:0] m);
        return (m >= `MR_SLOT_MIN) && (m <= `MR_SLOT_MAX);
    endfunction

    // register strobes
    logic cmd_wr;
    logic save_wr;
    logic mode_wr;
    logic page_wr;
    logic st_rd;
    assign cmd_wr  = wr_en && (addr == `MR_REG_CMD);
    assign save_wr = wr_en && (addr == `MR_REG_SAVE);
    assign mode_wr = wr_en && (addr == `MR_REG_MODE);
    assign page_wr = wr_en && (addr == `MR_REG_PAGE);
    assign st_rd   = rd_en && (addr == `MR_REG_STATUS);

    // command decode; err_off low means copy errors, so a plain add gives ON
    entry_s cmd_ent;
    logic   cmd_add;
    logic   cmd_ok;
    assign cmd_ent.src_mod  = wr_data[`MR_F_SMOD_LSB +: `MR_MOD_W];
    assign cmd_ent.src_port = wr_data[`MR_F_SPORT_LSB +: `MR_PORT_W];
    assign cmd_ent.dst_mod  = wr_data[`MR_F_DMOD_LSB +: `MR_MOD_W];
    assign cmd_ent.dst_port = wr_data[`MR_F_DPORT_LSB +: `MR_PORT_W];
    assign cmd_ent.err_off  = wr_data[`MR_F_ERR_OFF_BIT];
    assign cmd_add          = wr_data[`MR_F_OP_ADD_BIT];
    assign cmd_ok = slot_ok(cmd_ent.src_mod) && slot_ok(cmd_ent.dst_mod) &&
                    !((cmd_ent.src_mod == cmd_ent.dst_mod) &&
                      (cmd_ent.src_port == cmd_ent.dst_port));

    // staged table lookup of the exact pair
    logic [NENT-1:0] stg_vec;
    logic [NENT-1:0] act_vec;
    logic            stg_found;
    logic [IW-1:0]   stg_idx;
    logic [IW-1:0]   stg_last;
    logic            stg_full;
    assign stg_last = IW'(stg_cnt_reg - CW'(1));
    assign stg_full = (stg_cnt_reg == CW'(NENT));

    for (genvar g = 0; g < NENT; g++) begin : g_ent
        logic stg_raw;
        logic act_raw;
        entry_hit u_stg_hit (
            .ent      (stg_mem[g]),
            .src_mod  (cmd_ent.src_mod),
            .src_port (cmd_ent.src_port),
            .dst_mod  (cmd_ent.dst_mod),
            .dst_port (cmd_ent.dst_port),
            .use_dst  (1'b1),
            .hit      (stg_raw)
        );
        assign stg_vec[g] = stg_raw && (CW'(g) < stg_cnt_reg);
        // any number of entries may share a source; each one hits
        entry_hit u_act_hit (
            .ent      (act_mem[g]),
            .src_mod  (frm.src_mod),
            .src_port (frm.src_port),
            .dst_mod  (frm.src_mod),
            .dst_port (frm.src_port),
            .use_dst  (1'b0),
            .hit      (act_raw)
        );
        assign act_vec[g] = act_raw && (CW'(g) < act_cnt_reg) &&
                            (!act_mem[g].err_off || !frm.err) &&
                            !((act_mem[g].dst_mod == frm.src_mod) &&
                              (act_mem[g].dst_port == frm.src_port));
    end

    lowest_one #(
        .W  (NENT),
        .IW (IW)
    ) u_stg_pick (
        .vec   (stg_vec),
        .found (stg_found),
        .idx   (stg_idx)
    );

    // staged edits; delete moves the last entry into the hole to stay packed
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            stg_cnt_reg <= '0;
        end else if (cmd_wr && cmd_ok) begin
            if (cmd_add) begin
                if (stg_found) begin
                    stg_mem[stg_idx].err_off <= cmd_ent.err_off;
                end else if (!stg_full) begin
                    stg_mem[IW'(stg_cnt_reg)] <= cmd_ent;
                    stg_cnt_reg <= stg_cnt_reg + CW'(1);
                end
            end else if (stg_found) begin
                stg_mem[stg_idx] <= stg_mem[stg_last];
                stg_cnt_reg <= stg_cnt_reg - CW'(1);
            end
        end
    end

    // commit the whole staged table at once
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            act_cnt_reg <= '0;
        end else if (save_wr) begin
            for (int i = 0; i < NENT; i++) begin
                act_mem[i] <= stg_mem[i];
            end
            act_cnt_reg <= stg_cnt_reg;
        end
    end

    // sticky flags, cleared by a status read; a new event wins over the clear
    logic cmd_rej;
    assign cmd_rej = cmd_wr && (!cmd_ok || (cmd_add ? (!stg_found && stg_full) : !stg_found));

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            saved_reg <= 1'b0;
        end else if (save_wr) begin
            saved_reg <= 1'b1;
        end else if (st_rd) begin
            saved_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cmd_err_reg <= 1'b0;
        end else if (cmd_rej) begin
            cmd_err_reg <= 1'b1;
        end else if (st_rd) begin
            cmd_err_reg <= 1'b0;
        end
    end

    // one bit per slot; bit n-1 is slot n
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mode_reg <= `MR_MODE_RST;
        end else if (mode_wr) begin
            mode_reg <= wr_data[4:0];
        end
    end

    // readback groups
    logic [15:0] next_base;
    logic        has_next;
    logic        has_prev;
    logic [15:0] req_base;
    assign next_base = (16'(page_reg) + 16'h0001) * `MR_PAGE_SIZE;
    assign has_next  = next_base < 16'(act_cnt_reg);
    assign has_prev  = (page_reg != `MR_PAGE_RST);
    assign req_base  = 16'(wr_data[7:0]) * `MR_PAGE_SIZE;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            page_reg <= `MR_PAGE_RST;
        end else if (page_wr && ((wr_data[7:0] == `MR_PAGE_RST) ||
                                 (req_base < 16'(act_cnt_reg)))) begin
            page_reg <= wr_data[7:0];
        end
    end

    // normal path is one flop deep and never looks at the mirror state
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            fwd_valid <= 1'b0;
            fwd_frame <= '0;
        end else begin
            fwd_valid <= frm_valid;
            fwd_frame <= frm;
        end
    end

    // mirror scan: one copy per cycle from the pending hit vector
    logic [`MR_MOD_W-1:0] mode_bit;
    logic                 mode_on;
    logic [NENT-1:0]      new_vec;
    logic                 busy;
    logic                 pick_found;
    logic [IW-1:0]        pick_idx;
    logic [NENT-1:0]      pick_hot;
    assign mode_bit = frm.src_mod - `MR_SLOT_MIN;
    // slot number minus one (MR_SLOT_MIN) selects the mode bit
    assign mode_on  = slot_ok(frm.src_mod) && mode_reg[mode_bit];
    assign new_vec  = mode_on ? act_vec : '0;
    assign busy     = |pend_reg;
    assign pick_hot = NENT'(1) << pick_idx;

    lowest_one #(
        .W  (NENT),
        .IW (IW)
    ) u_mir_pick (
        .vec   (pend_reg),
        .found (pick_found),
        .idx   (pick_idx)
    );

    // a save rewrites the table under the scan, so the scan is abandoned
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pend_reg <= '0;
        end else if (save_wr) begin
            pend_reg <= '0;
        end else if (busy) begin
            pend_reg <= pend_reg & ~pick_hot;
        end else if (frm_valid) begin
            pend_reg <= new_vec;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cur_reg <= '0;
        end else if (frm_valid && !busy) begin
            cur_reg <= frm;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mir_valid <= 1'b0;
            mir_copy  <= '0;
        end else if (busy && pick_found && mir_ready && !save_wr) begin
            mir_valid         <= 1'b1;
            mir_copy.tag      <= cur_reg.tag;
            mir_copy.err      <= cur_reg.err;
            mir_copy.dst_mod  <= act_mem[pick_idx].dst_mod;
            mir_copy.dst_port <= act_mem[pick_idx].dst_port;
        end else begin
            mir_valid <= 1'b0;
        end
    end

    // congested copies and frames with mirror hits arriving mid-scan are counted, not held
    logic [1:0]  drop_inc;
    logic [16:0] drop_sum;
    assign drop_inc = {1'b0, busy && (!mir_ready || save_wr)} +
                      {1'b0, frm_valid && busy && (|new_vec)};
    assign drop_sum = {1'b0, drop_reg} + {15'h0000, drop_inc};

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            drop_reg <= '0;
        end else if (drop_sum[16]) begin
            drop_reg <= `MR_DROP_MAX;
        end else begin
            drop_reg <= drop_sum[15:0];
        end
    end

    // register reads, answered in the following cycle only
    logic [7:0]  view_off;
    logic        view_hit;
    logic [15:0] view_idx;
    entry_s      view_ent;
    assign view_off = addr - `MR_REG_VIEW;
    assign view_hit = (addr >= `MR_REG_VIEW) && (view_off < `MR_VIEW_BYTES) &&
                      (addr[1:0] == 2'b00);
    assign view_idx = 16'(page_reg) * `MR_PAGE_SIZE + 16'(view_off[7:2]);
    assign view_ent = act_mem[IW'(view_idx)];

    always_comb begin
        rd_next = `MR_WORD_RST;
        case (addr)
            `MR_REG_MODE: begin
                rd_next[4:0] = mode_reg;
            end
            `MR_REG_STATUS: begin
                rd_next[`MR_ST_SAVED_BIT]  = saved_reg;
                rd_next[`MR_ST_CMDERR_BIT] = cmd_err_reg;
                rd_next[`MR_ST_NEXT_BIT]   = has_next;
                rd_next[`MR_ST_PREV_BIT]   = has_prev;
                rd_next[15:8]              = 8'(act_cnt_reg);
                rd_next[23:16]             = page_reg;
            end
            `MR_REG_PAGE: begin
                rd_next[7:0] = page_reg;
            end
            `MR_REG_DROPS: begin
                rd_next[15:0] = drop_reg;
            end
            default: begin
                if (view_hit && (view_idx < 16'(act_cnt_reg))) begin
                    rd_next[`MR_F_SMOD_LSB +: `MR_MOD_W]   = view_ent.src_mod;
                    rd_next[`MR_F_SPORT_LSB +: `MR_PORT_W] = view_ent.src_port;
                    rd_next[`MR_F_DMOD_LSB +: `MR_MOD_W]   = view_ent.dst_mod;
                    rd_next[`MR_F_DPORT_LSB +: `MR_PORT_W] = view_ent.dst_port;
                    rd_next[`MR_F_ERR_OFF_BIT]             = view_ent.err_off;
                    rd_next[`MR_F_VALID_BIT]               = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rd_data <= `MR_WORD_RST;
        end else if (rd_en) begin
            rd_data <= rd_next;
        end else begin
            rd_data <= `MR_WORD_RST;
        end
    end

    // checks
    chk_fwd_always: assert property (@(posedge clk_sys) disable iff (!rstn)
        frm_valid |=> fwd_valid && (fwd_frame == $past(frm)))
        else $error("arriving frame not forwarded");

    chk_mode_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
        (frm_valid && !busy && !mode_on) |=> !busy)
        else $error("mirror hit outside bridging mode");

    chk_slot_range: assert property (@(posedge clk_sys) disable iff (!rstn)
        mir_valid |-> (mir_copy.dst_mod >= `MR_SLOT_MIN) && (mir_copy.dst_mod <= `MR_SLOT_MAX))
        else $error("copy sent to slot out of range");

    chk_no_loopback: assert property (@(posedge clk_sys) disable iff (!rstn)
        mir_valid |-> !((mir_copy.dst_mod == cur_reg.src_mod) &&
                        (mir_copy.dst_port == cur_reg.src_port)))
        else $error("copy returned to ingress port");

    chk_err_filter: assert property (@(posedge clk_sys) disable iff (!rstn)
        (busy && mir_ready && !save_wr && cur_reg.err) |-> !act_mem[pick_idx].err_off)
        else $error("errored copy sent with error copying off");

    chk_congest_drop: assert property (@(posedge clk_sys) disable iff (!rstn)
        (busy && !mir_ready) |=> !mir_valid && (drop_reg != $past(drop_reg) ||
                                                drop_reg == `MR_DROP_MAX))
        else $error("congested copy neither dropped nor counted");

    chk_save_commit: assert property (@(posedge clk_sys) disable iff (!rstn)
        save_wr |=> (act_cnt_reg == $past(stg_cnt_reg)) && saved_reg && (pend_reg == '0))
        else $error("save did not commit staged table");

    chk_add_grows: assert property (@(posedge clk_sys) disable iff (!rstn)
        (cmd_wr && cmd_ok && cmd_add && !stg_found && !stg_full) |=>
            (stg_cnt_reg == $past(stg_cnt_reg) + CW'(1)))
        else $error("add did not grow staged table");

    chk_del_shrinks: assert property (@(posedge clk_sys) disable iff (!rstn)
        (cmd_wr && cmd_ok && !cmd_add && stg_found) |=>
            (stg_cnt_reg == $past(stg_cnt_reg) - CW'(1)))
        else $error("delete did not shrink staged table");

    chk_read_slot: assert property (@(posedge clk_sys) disable iff (!rstn)
        !rd_en |=> (rd_data == `MR_WORD_RST))
        else $error("read data outside the answer cycle");

endmodule
`default_nettype wire

// ==== dv/mirror_monitor_sink.sv ====
`timescale 1ns/10ps
`default_nettype none
module mirror_monitor_sink
    import mirror_pkg::*;
(
    // clock and reset
    input  wire logic   clk_sys,
    input  wire logic   rstn,
    // bench control
    input  wire logic   stall,
    // copies from the block
    input  wire logic   mir_valid,
    input  wire copy_s  mir_copy,
    output logic        mir_ready,
    // capture
    output logic [7:0]  n_got,
    output copy_s       got_q [0:15]
);
    // a congested analyzer port only withholds ready; it never pushes back on forwarding
    assign mir_ready = ~stall;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            n_got <= 8'h00;
        end else if (mir_valid) begin
            got_q[n_got[3:0]] <= mir_copy;
            n_got             <= n_got + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ==== dv/port_mirror_redirect_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "mirror_defines.svh"
module port_mirror_redirect_bench
    import mirror_pkg::*;
;
    logic         clk_sys   = 1'b0;
    logic         rstn      = 1'b0;
    logic [7:0]   addr      = 8'h00;
    logic [31:0]  wr_data   = 32'h0000_0000;
    logic         wr_en     = 1'b0;
    logic         rd_en     = 1'b0;
    logic [31:0]  rd_data;
    logic         frm_valid = 1'b0;
    frame_s       frm       = '0;
    logic         fwd_valid;
    frame_s       fwd_frame;
    logic         mir_ready;
    logic         mir_valid;
    logic         stall     = 1'b0;
    copy_s        mir_copy;
    logic [7:0]   n_got;
    copy_s        got_q [0:15];
    copy_s        exp_q [$];
    logic [31:0]  tbl [0:3];
    int           n_mismatch = 0;
    int           checked    = 0;
    int           base;

    always #5 clk_sys = ~clk_sys;

    port_mirror_redirect #(.NENT(16)) port_mirror_redirect_inst (
        .clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .frm_valid(frm_valid), .frm(frm),
        .fwd_valid(fwd_valid), .fwd_frame(fwd_frame), .mir_ready(mir_ready),
        .mir_valid(mir_valid), .mir_copy(mir_copy));

    mirror_monitor_sink mirror_monitor_sink_inst (
        .clk_sys(clk_sys), .rstn(rstn), .stall(stall), .mir_valid(mir_valid),
        .mir_copy(mir_copy), .mir_ready(mir_ready), .n_got(n_got), .got_q(got_q));

    task automatic conclude();
        $display("counts: checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [31:0] cmd(input logic add, input logic eoff,
        input logic [2:0] sm, input logic [3:0] sp, input logic [2:0] dm, input logic [3:0] dp);
        cmd = {7'h00, add, 7'h00, eoff, dp, 1'b0, dm, sp, 1'b0, sm};
    endfunction

    // called just after a rising edge; leaves one idle cycle so strobes never collide
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clk_sys);
        wr_en   <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what,
        input logic [31:0] m = 32'hFFFF_FFFF);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        chk(rd_data & m, e, what);
        @(posedge clk_sys);
    endtask

    function automatic copy_s cp(input logic [2:0] dm, input logic [3:0] dp,
        input logic er, input logic [7:0] tg);
        cp = '{tag: tg, err: er, dst_port: dp, dst_mod: dm};
    endfunction

    // copies are compared against exp_q, filled by the caller beforehand
    task automatic send(input logic [2:0] sm, input logic [3:0] sp, input logic er,
        input logic [7:0] tg);
        frame_s f;
        f = '{tag: tg, err: er, fwd: 16'h00A5, src_port: sp, src_mod: sm};
        base = int'(n_got);
        frm       <= f;
        frm_valid <= 1'b1;
        @(posedge clk_sys);
        frm_valid <= 1'b0;
        #1;
        chk({31'h0, fwd_valid}, 32'h1, "fwd_valid");
        chk(fwd_frame, f, "fwd_frame");
        repeat (12) @(posedge clk_sys);
        #1;
        chk(32'(int'(n_got) - base), 32'(exp_q.size()), "copy count");
        foreach (exp_q[i]) begin
            chk({16'h0, got_q[(base + i) % 16]}, {16'h0, exp_q[i]}, "copy");
        end
        exp_q.delete();
        @(posedge clk_sys);
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        conclude();
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        rd(`MR_REG_MODE, 32'h0, "mode rst");
        rd(`MR_REG_STATUS, 32'h0, "status rst");
        rd(`MR_REG_PAGE, 32'h0, "page rst");
        rd(`MR_REG_DROPS, 32'h0, "drops rst");
        rd(8'h30, 32'h0, "unmapped");
        $display("test reset values done");

        foreach (tbl[i]) begin
            wr(`MR_REG_CMD, cmd(1'b1, 1'b0, 3'(i * 7 % 8), 4'h1, (i == 3) ? 3'h0 : 3'h3, 4'h2));
            rd(`MR_REG_STATUS, 32'h2, "bad slot");
        end
        wr(`MR_REG_CMD, cmd(1'b1, 1'b0, 3'h1, 4'h1, 3'h1, 4'h1));
        rd(`MR_REG_STATUS, 32'h2, "self entry");
        $display("test refusals done");

        tbl[0] = cmd(1'b0, 1'b0, 3'h1, 4'h1, 3'h3, 4'h2);
        tbl[1] = cmd(1'b0, 1'b1, 3'h1, 4'h1, 3'h3, 4'h3);
        tbl[2] = cmd(1'b0, 1'b0, 3'h1, 4'h1, 3'h3, 4'h4);
        tbl[3] = cmd(1'b0, 1'b0, 3'h2, 4'h2, 3'h1, 4'h1);
        foreach (tbl[i]) wr(`MR_REG_CMD, tbl[i] | 32'h0100_0000);
        rd(`MR_REG_STATUS, 32'h0, "staged hidden");
        wr(`MR_REG_SAVE, 32'h0);
        rd(`MR_REG_STATUS, 32'h0401, "saved");
        rd(`MR_REG_STATUS, 32'h0400, "clear on read");
        foreach (tbl[i]) rd(8'(8'h40 + 4 * i), 32'h8000_0000 | tbl[i], "view", 32'h8001_FFFF);
        rd(8'h40, 32'h0, "err copy default", 32'h0001_0000);
        $display("test table done");

        send(3'h1, 4'h1, 1'b0, 8'h11);
        wr(`MR_REG_MODE, 32'h3);
        rd(`MR_REG_MODE, 32'h3, "mode");
        exp_q = '{cp(3'h3, 4'h2, 1'b0, 8'h12), cp(3'h3, 4'h3, 1'b0, 8'h12),
                  cp(3'h3, 4'h4, 1'b0, 8'h12)};
        send(3'h1, 4'h1, 1'b0, 8'h12);
        exp_q = '{cp(3'h3, 4'h2, 1'b1, 8'h13), cp(3'h3, 4'h4, 1'b1, 8'h13)};
        send(3'h1, 4'h1, 1'b1, 8'h13);
        exp_q = '{cp(3'h1, 4'h1, 1'b0, 8'h14)};
        send(3'h2, 4'h2, 1'b0, 8'h14);
        send(3'h3, 4'h3, 1'b0, 8'h15);
        $display("test mirroring done");

        stall <= 1'b1;
        send(3'h1, 4'h1, 1'b0, 8'h16);
        stall <= 1'b0;
        rd(`MR_REG_DROPS, 32'h3, "drops");
        $display("test congestion done");

        for (int p = 1; p <= 7; p++) begin
            wr(`MR_REG_CMD, cmd(1'b1, 1'b0, 3'h4, 4'(p), 3'h5, 4'(p)));
        end
        wr(`MR_REG_CMD, cmd(1'b0, 1'b0, 3'h4, 4'h9, 3'h5, 4'h9));
        rd(`MR_REG_STATUS, 32'h0402, "delete absent");
        wr(`MR_REG_SAVE, 32'h0);
        rd(`MR_REG_STATUS, 32'h0B05, "next group");
        wr(`MR_REG_PAGE, 32'h1);
        rd(`MR_REG_STATUS, 32'h0001_0B08, "last group");
        rd(8'h40, 32'h8000_0000 | cmd(1'b0, 1'b0, 3'h4, 4'h7, 3'h5, 4'h7), "page view",
           32'h8001_FFFF);
        rd(8'h44, 32'h0, "beyond count");
        wr(`MR_REG_PAGE, 32'h2);
        rd(`MR_REG_PAGE, 32'h1, "page refused");
        wr(`MR_REG_CMD, tbl[3]);
        wr(`MR_REG_SAVE, 32'h0);
        wr(`MR_REG_PAGE, 32'h0);
        rd(`MR_REG_STATUS, 32'h0A01, "ten entries");
        rd(8'h4C, 32'h8000_0000 | cmd(1'b0, 1'b0, 3'h4, 4'h7, 3'h5, 4'h7), "compacted",
           32'h8001_FFFF);
        $display("test paging done");
        conclude();
    end
endmodule
`default_nettype wire
